// File: hw/cst_timers.sv
/*
  Four calendar schedule timers with an APB register slave and a
  save/restore port to a non-volatile store.
  Assumes i_tod/i_wday come from a real-time clock on the same clock;
  i_pwr_fail is an asynchronous pin and is synchronised here. The store
  answers i_nv_ack once per request, one cycle or later.
*/
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module cst_timers
  import cst_pkg::*;
#(
  parameter int unsigned N = NUM_TIMERS
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // apb slave
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [7:0]      i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  // calendar
  input  wire cst_tod_t        i_tod,
  input  wire logic [2:0]      i_wday,
  // power and non-volatile store
  input  wire logic            i_pwr_fail,
  output logic                 o_nv_req,
  output logic                 o_nv_wr,
  output logic      [N-1:0]    o_nv_wdata,
  input  wire logic [N-1:0]    i_nv_rdata,
  input  wire logic            i_nv_ack,
  // timer outputs to logic, blocking and output matrix
  output logic      [N-1:0]    o_sched_out
);

  typedef enum logic [1:0] {NV_RESTORE, NV_RUN, NV_SAVE, NV_DONE} cst_nv_t;

  cst_tod_t        on_r   [N];
  cst_tod_t        off_r  [N];
  logic [3:0]      mode_r [N];
  logic [N-1:0]    state_r;
  logic [N-1:0]    state_nxt;
  logic [N-1:0]    hit_on;
  logic [N-1:0]    hit_off;
  logic [N-1:0]    force_wr;
  cst_nv_t         nv_r;
  logic            pf_s1_r;
  logic            pf_s2_r;
  logic            sec_q_r;
  logic            sec_tick;
  logic            running;

  cst_apb_req_t    req;
  logic            wr_acc;
  logic            rd_acc;
  logic [3:0]      tsel;
  logic [7:0]      tofs;
  logic            in_tmr;

  assign req      = '{sel: i_psel, en: i_penable, wr: i_pwrite, addr: i_paddr, wdata: i_pwdata};
  assign wr_acc   = req.sel && req.en && req.wr && o_pready;
  assign rd_acc   = req.sel && !req.en && !req.wr;
  assign tsel     = req.addr[7:4];
  assign tofs     = {4'h0, req.addr[3:0]};
  assign in_tmr   = (req.addr <= ADR_LAST_TMR) && (req.addr[1:0] == 2'h0);
  assign running  = (nv_r == NV_RUN);

  // power-fail pin crosses into the clock domain
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pf_s1_r <= 1'b0;
      pf_s2_r <= 1'b0;
    end else begin
      pf_s1_r <= i_pwr_fail;
      pf_s2_r <= pf_s1_r;
    end
  end

  // one pulse per new second so each match fires once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_q_r <= 1'b0;
    end else begin
      sec_q_r <= i_tod.sec[0];
    end
  end
  assign sec_tick = (sec_q_r != i_tod.sec[0]);

  // per-timer day qualification and match
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_tmr
      logic day_ok;
      always_comb begin
        unique case (mode_r[g])
          MODE_DAILY: day_ok = 1'b1;
          MODE_WWEEK: day_ok = (i_wday <= WD_FRI);
          MODE_SIXDY: day_ok = (i_wday <= WD_SAT);
          MODE_WKEND: day_ok = (i_wday == WD_SAT) || (i_wday == WD_SUN);
          default: begin
            // single-weekday modes; off and unused codes never qualify
            day_ok = (mode_r[g] >= MODE_MON) && (mode_r[g] <= MODE_SUN)
                     && (mode_r[g] - MODE_MON == {1'b0, i_wday});
          end
        endcase
      end
      assign hit_on[g]   = running && sec_tick && day_ok && (i_tod == on_r[g]);
      assign hit_off[g]  = running && sec_tick && day_ok && (i_tod == off_r[g]);
      assign force_wr[g] = wr_acc && in_tmr && (tsel == 4'(g)) && (tofs == OFS_STATE)
                           && (mode_r[g] != MODE_OFF);
    end
  endgenerate

  // settings registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < N; i++) begin
        on_r[i]   <= RST_TOD;
        off_r[i]  <= RST_TOD;
        mode_r[i] <= RST_MODE;
      end
    end else if (wr_acc && in_tmr) begin
      for (int i = 0; i < N; i++) begin
        if (tsel == 4'(i)) begin
          if (tofs == OFS_ON) begin
            on_r[i] <= req.wdata[TOD_W-1:0];
          end
          if (tofs == OFS_OFF) begin
            off_r[i] <= req.wdata[TOD_W-1:0];
          end
          // codes above the last mode are dropped so the decode never sees them
          if ((tofs == OFS_MODE) && (req.wdata[3:0] <= MODE_WKEND)) begin
            mode_r[i] <= req.wdata[3:0];
          end
        end
      end
    end
  end

  // output state: restore, schedule, force
  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < N; i++) begin
      if (mode_r[i] == MODE_OFF) begin
        state_nxt[i] = 1'b0;
      end else if (force_wr[i]) begin
        state_nxt[i] = req.wdata[0];
      end else if (hit_off[i]) begin
        state_nxt[i] = 1'b0;
      end else if (hit_on[i]) begin
        state_nxt[i] = 1'b1;
      end
    end
    if (nv_r == NV_RESTORE && i_nv_ack) begin
      for (int i = 0; i < N; i++) begin
        state_nxt[i] = i_nv_rdata[i] && (mode_r[i] != MODE_OFF);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sched_out <= '0;
    end else begin
      o_sched_out <= state_nxt;
    end
  end

  // non-volatile sequencer: restore at start, save on power fail
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_r       <= NV_RESTORE;
      o_nv_req   <= 1'b1;
      o_nv_wr    <= 1'b0;
      o_nv_wdata <= '0;
    end else begin
      unique case (nv_r)
        NV_RESTORE: begin
          if (i_nv_ack) begin
            nv_r     <= NV_RUN;
            o_nv_req <= 1'b0;
          end
        end
        NV_RUN: begin
          if (pf_s2_r) begin
            nv_r       <= NV_SAVE;
            o_nv_req   <= 1'b1;
            o_nv_wr    <= 1'b1;
            o_nv_wdata <= state_r;
          end
        end
        NV_SAVE: begin
          if (i_nv_ack) begin
            nv_r     <= NV_DONE;
            o_nv_req <= 1'b0;
            o_nv_wr  <= 1'b0;
          end
        end
        NV_DONE: begin
          // schedule stays frozen while the power-fail level is held;
          // a brownout that recovers resumes without a restore pass
          if (!pf_s2_r) begin
            nv_r <= NV_RUN;
          end
        end
      endcase
    end
  end

  // apb: one wait-free access phase, read data prepared in setup
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= req.sel && !req.en;
    end
  end

  // error raised with ready so the master sees both at the same edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= req.sel && !req.en && !in_tmr && (req.addr != ADR_NVSTAT);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= '0;
    end else if (rd_acc) begin
      o_prdata <= '0;
      if (req.addr == ADR_NVSTAT) begin
        o_prdata <= {30'h0, nv_r};
      end else if (in_tmr) begin
        for (int i = 0; i < N; i++) begin
          if (tsel == 4'(i)) begin
            unique case (tofs)
              OFS_ON:   o_prdata <= {15'h0, on_r[i]};
              OFS_OFF:  o_prdata <= {15'h0, off_r[i]};
              OFS_MODE: o_prdata <= {28'h0, mode_r[i]};
              OFS_STATE: begin
                // an unused timer reports ST_NOTUSED, not its frozen zero
                if (mode_r[i] == MODE_OFF) begin
                  o_prdata <= {30'h0, ST_NOTUSED};
                end else if (state_r[i]) begin
                  o_prdata <= {30'h0, ST_ACTIVE};
                end else begin
                  o_prdata <= {30'h0, ST_INACTIVE};
                end
              end
              default: begin
                o_prdata <= '0;
              end
            endcase
          end
        end
      end
    end
  end

endmodule : cst_timers

// File: include/cst_pkg.sv
/*
  Package for the calendar schedule timers: register map, field layout,
  reset values, mode encoding and shared carrier types.
  Assumes a 32-bit APB master, a real-time clock giving BCD-free binary
  time of day and weekday, and a non-volatile store with a simple
  request/acknowledge word port.
*/
//
// Contract
// - four independent timers, each with on time, off time and a mode that selects one of twelve modes.
// - each timer holds a switch-on time in hours, minutes and seconds, activating on allowed days.
// - each timer holds a switch-off time in hours, minutes and seconds, deactivating on allowed days.
// - in not-in-use mode the timer stops and its output is held at 0.
// - daily mode switches on and off every day of the week.
// - seven single-weekday modes switch only on the selected weekday.
// - working-week mode switches Monday to Friday only.
// - six-day mode switches Monday to Saturday only.
// - weekend mode switches on Saturday and Sunday only.
// - software may force any in-use timer to 1 or 0.
// - forcing is a plain write to the state field with no enable flag.
// - a forced state lasts until the next force or the next scheduled opposite transition.
// - on auxiliary power loss each timer state is saved to non-volatile storage.
// - at start-up each timer state is restored from storage before scheduling resumes; the code restores 0 to timers still in not-in-use mode at the ack.
// - each timer output feeds programmable logic, blocking logic and the output matrix.
package cst_pkg;

  localparam int unsigned NUM_TIMERS = 4;

  // time of day fields, binary
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } cst_tod_t;

  // weekday coding: 0 = Monday .. 6 = Sunday
  localparam logic [2:0] WD_MON = 3'h0;
  localparam logic [2:0] WD_FRI = 3'h4;
  localparam logic [2:0] WD_SAT = 3'h5;
  localparam logic [2:0] WD_SUN = 3'h6;

  // mode codes; single-weekday modes are MODE_MON + weekday
  localparam logic [3:0] MODE_OFF   = 4'h0;
  localparam logic [3:0] MODE_DAILY = 4'h1;
  localparam logic [3:0] MODE_MON   = 4'h2;
  localparam logic [3:0] MODE_SUN   = 4'h8;
  localparam logic [3:0] MODE_WWEEK = 4'h9;
  localparam logic [3:0] MODE_SIXDY = 4'hA;
  localparam logic [3:0] MODE_WKEND = 4'hB;

  // register map: per timer a block of four words, then one read-only nv status word
  localparam logic [7:0] TMR_STRIDE   = 8'h10;
  localparam logic [7:0] OFS_ON       = 8'h00;
  localparam logic [7:0] OFS_OFF      = 8'h04;
  localparam logic [7:0] OFS_MODE     = 8'h08;
  localparam logic [7:0] OFS_STATE    = 8'h0C;
  localparam logic [7:0] ADR_NVSTAT   = 8'h40;
  localparam logic [7:0] ADR_LAST_TMR = 8'h3C;

  // time fields in the on/off registers
  localparam int unsigned TOD_W = 17;

  // state field readback
  localparam logic [1:0] ST_INACTIVE = 2'h0;
  localparam logic [1:0] ST_ACTIVE   = 2'h1;
  localparam logic [1:0] ST_NOTUSED  = 2'h2;

  // reset values
  localparam logic [TOD_W-1:0] RST_TOD  = '0;
  localparam logic [3:0]       RST_MODE = MODE_OFF;

  typedef struct packed {
    logic       sel;
    logic       en;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cst_apb_req_t;

endpackage : cst_pkg

// File: testbench/calendar_schedule_timers_tb.sv
/* self-checking bench for cst_timers with a store model.
   assumes zero-wait apb and the store model ack */
`timescale 1ns/100ps
module calendar_schedule_timers_tb import cst_pkg::*; ;
  logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_pwr_fail = 0;
  logic [7:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, rd;
  logic o_pready, o_pslverr, o_nv_req, o_nv_wr, i_nv_ack, err, ok;
  logic [3:0] o_nv_wdata, i_nv_rdata, o_sched_out, saved, es, dly = 4'h9;
  logic [2:0] i_wday = '0;
  cst_tod_t i_tod = '0, ton, toff;
  int mismatches = 0, checks_done = 0, t;
  always #5 i_clk = ~i_clk;
  cst_timers uut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_tod, .i_wday, .i_pwr_fail, .o_nv_req, .o_nv_wr,
    .o_nv_wdata, .i_nv_rdata, .i_nv_ack, .o_sched_out);
  cst_nv_model u_nv (.i_clk, .i_rst_n, .i_req(o_nv_req), .i_wr(o_nv_wr), .i_wdata(o_nv_wdata),
    .i_dly(dly), .o_rdata(i_nv_rdata), .o_saved(saved), .o_ack(i_nv_ack));
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      conclude();
    end
    {rd, err} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'b00;
  endtask : apb
  // the preceding flip of the lowest seconds bit is what arms the match
  task automatic tick(input cst_tod_t tm);
    i_tod <= tm ^ 17'h1;
    repeat (3) @(posedge i_clk);
    i_tod <= tm;
    repeat (4) @(posedge i_clk);
  endtask : tick
  function automatic logic day_ok(input logic [3:0] m, input logic [2:0] w);
    case (m)
      MODE_DAILY: return 1'b1;
      MODE_WWEEK: return w <= WD_FRI;
      MODE_SIXDY: return w <= WD_SAT;
      MODE_WKEND: return w >= WD_SAT;
      default: return m >= MODE_MON && m <= MODE_SUN && m - MODE_MON == {1'b0, w};
    endcase
  endfunction : day_ok
  initial begin
    void'($urandom(32'hDB10E6F2));
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1, OFS_MODE, MODE_DAILY);
    apb(1, TMR_STRIDE + OFS_MODE, MODE_DAILY);
    for (t = 0; t < 100 && o_nv_req !== 1'b0; t++) @(posedge i_clk);
    if (t >= 100) begin
      mismatches++;
      conclude();
    end
    check("restore", o_sched_out, 4'hA & 4'h3);
    apb(0, ADR_NVSTAT, 0);
    check("nvstat", rd, 1);
    $display("restore test done");
    for (int m = 1; m < 12; m++) for (int w = 0; w < 7; w++) begin
      t = $urandom % 4;
      ton = 17'($urandom);
      ton.hour = 5'(1 + $urandom % 23);
      ton.min = 6'($urandom % 60);
      ton.sec = 6'($urandom % 60);
      toff = ton;
      toff.hour = ton.hour % 5'h17 + 5'h1;
      ok = day_ok(4'(m), 3'(w));
      i_wday <= 3'(w);
      apb(1, 8'(t * 16) + OFS_ON, 32'(ton));
      apb(1, 8'(t * 16) + OFS_OFF, 32'(toff));
      apb(1, 8'(t * 16) + OFS_MODE, m);
      apb(1, 8'(t * 16) + OFS_STATE, 0);
      tick(ton);
      check("on", o_sched_out[t], ok);
      apb(1, 8'(t * 16) + OFS_STATE, 1);
      repeat (2) @(posedge i_clk);
      check("force", o_sched_out[t], 1);
      tick(toff);
      check("off", o_sched_out[t], !ok);
      apb(0, 8'(t * 16) + OFS_STATE, 0);
      check("state", rd, ok ? ST_INACTIVE : ST_ACTIVE);
    end
    $display("mode test done");
    apb(1, OFS_MODE, MODE_OFF);
    apb(1, OFS_STATE, 1);
    apb(1, OFS_MODE, 32'hC);
    apb(0, OFS_MODE, 0);
    check("mode", rd, MODE_OFF);
    apb(0, OFS_STATE, 0);
    check("unused", rd, ST_NOTUSED);
    check("unused out", o_sched_out[0], 0);
    apb(0, 8'h44, 0);
    check("slverr", 32'(err), 1);
    check("unmapped rd", rd, 0);
    $display("refusal test done");
    es = 4'h0;
    for (t = 1; t < 4; t++) begin
      es[t] = 1'($urandom);
      apb(1, 8'(t * 16) + OFS_MODE, MODE_DAILY);
      apb(1, 8'(t * 16) + OFS_STATE, es[t]);
    end
    dly <= 4'hF;
    i_pwr_fail <= 1'b1;
    for (t = 0; t < 100 && !(i_nv_ack === 1'b1 && o_nv_wr === 1'b1); t++) @(posedge i_clk);
    if (t >= 100) begin
      mismatches++;
      conclude();
    end
    @(posedge i_clk);
    check("saved", saved, es);
    apb(0, ADR_NVSTAT, 0);
    check("nvstat", rd, 3);
    i_pwr_fail <= 1'b0;
    repeat (6) @(posedge i_clk);
    apb(0, ADR_NVSTAT, 0);
    check("nvstat", rd, 1);
    $display("save test done");
    conclude();
  end
endmodule : calendar_schedule_timers_tb

// File: testbench/cst_nv_model.sv
/* non-volatile store model for the timer states.
   assumes a level request held until one ack pulse */
`timescale 1ns/100ps
module cst_nv_model #(parameter logic [3:0] INIT = 4'hA) (
  input  wire logic       i_clk, i_rst_n, i_req, i_wr,
  input  wire logic [3:0] i_wdata, i_dly,
  output logic      [3:0] o_rdata, o_saved,
  output logic            o_ack
);
  logic [3:0] cnt;
  logic       done;
  initial begin
    o_saved = INIT;
    o_ack = 1'b0;
  end
  // idle data lines show the inverse so a stale sample cannot pass
  assign o_rdata = o_ack ? o_saved : ~o_saved;
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    if (!i_rst_n || !i_req) begin
      cnt <= '0;
      done <= 1'b0;
    end else if (!done && cnt == i_dly) begin
      o_ack <= 1'b1;
      done <= 1'b1;
      if (i_wr) o_saved <= i_wdata;
    end else if (!done) cnt <= cnt + 4'h1;
  end
endmodule : cst_nv_model

// File: testbench/cst_timers_asserts.sv
/* port checker for cst_timers.
   assumes an apb master that keeps the protocol */
`timescale 1ns/100ps
module cst_timers_asserts import cst_pkg::*; #(parameter int unsigned N = NUM_TIMERS) (
  input wire logic         i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready,
  input wire logic         o_pslverr, i_pwr_fail, o_nv_req, o_nv_wr, i_nv_ack,
  input wire logic [7:0]   i_paddr,
  input wire logic [31:0]  i_pwdata, o_prdata,
  input wire cst_tod_t     i_tod,
  input wire logic [2:0]   i_wday,
  input wire logic [N-1:0] o_nv_wdata, i_nv_rdata, o_sched_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0]   md_r [N];
  logic [N-1:0] frc_r;
  logic [2:0]   cause_r;
  cst_tod_t     tod_r;
  wire wr_acc = i_psel && i_penable && i_pwrite && o_pready;
  wire tmr_ad = i_paddr < ADR_NVSTAT;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int t = 0; t < N; t++) md_r[t] <= MODE_OFF;
      frc_r <= '0;
      cause_r <= '0;
      tod_r <= '0;
    end else begin
      if (wr_acc && tmr_ad && i_paddr[3:0] == 4'h8 && i_pwdata[3:0] <= MODE_WKEND)
        md_r[i_paddr[5:4]] <= i_pwdata[3:0];
      if (wr_acc && tmr_ad && i_paddr[3:0] == 4'hC) frc_r[i_paddr[5:4]] <= i_pwdata[0];
      cause_r <= {cause_r[1:0], wr_acc || i_nv_ack || i_tod != tod_r};
      tod_r <= i_tod;
    end
  end
  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_access; i_psel && i_penable; endsequence
  a_ready_setup: assert property (s_setup ##1 s_access |-> o_pready)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_read: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == '0)
    else $error("bad unmapped read");
  a_nv_hold: assert property (o_nv_req && !i_nv_ack |=> o_nv_req && $stable(o_nv_wr))
    else $error("store request dropped early");
  a_save_start: assert property ($rose(i_pwr_fail) |-> ##[2:5] o_nv_req && o_nv_wr)
    else $error("no save after power fail");
  a_save_data: assert property (o_nv_req && o_nv_wr |-> o_nv_wdata == o_sched_out)
    else $error("saved word differs from outputs");
  a_restore_quiet: assert property (o_nv_req && !o_nv_wr && !$past(i_nv_ack) |-> o_sched_out == '0)
    else $error("output active before restore");
  a_change_cause: assert property ($changed(o_sched_out) |-> |cause_r)
    else $error("output changed without cause");
  for (genvar t = 0; t < N; t++) begin : g_t
    a_off_zero: assert property (md_r[t] == MODE_OFF && $past(md_r[t], 2) == MODE_OFF |-> !o_sched_out[t])
      else $error("unused timer output high");
    a_force_state: assert property (wr_acc && i_paddr == 8'(t * 16) + OFS_STATE && md_r[t] != MODE_OFF |-> ##[1:2] o_sched_out[t] == frc_r[t])
      else $error("force write not applied");
  end
endmodule : cst_timers_asserts
bind cst_timers cst_timers_asserts #(.N(N)) u_chk (.i_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .o_pready, .o_pslverr, .i_pwr_fail, .o_nv_req, .o_nv_wr, .i_nv_ack, .i_paddr,
  .i_pwdata, .o_prdata, .i_tod, .i_wday, .o_nv_wdata, .i_nv_rdata, .o_sched_out);
